// ===== gpio_port_map.vh
// Register offsets, field positions and reset values of the GPIO port.
// Assumes inclusion by the port module; definitions only.
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

`define ADDR_W 4

// Register offsets
`define OFF_DIRECTION 4'h0
`define OFF_OUTPUT_DATA 4'h1
`define OFF_INPUT_SAMPLE 4'h2
`define OFF_MCU_CONTROL 4'h3
`define OFF_IRQ_STATUS 4'h4
`define OFF_IRQ_CLEAR 4'h5
`define OFF_IRQ_ENABLE 4'h6

// Field positions in the control register
`define CTRL_PUD_BIT 0

// Reset values
`define RST_DIRECTION 8'h00
`define RST_OUTPUT_DATA 8'h00
`define RST_MCU_CONTROL 8'h00
`define RST_IRQ_STATUS 8'h00
`define RST_IRQ_ENABLE 8'h00
`define RST_INPUT_SAMPLE 8'h00

// Synchroniser delay figures, in half clock periods
`define SYNC_MIN_HALF 1
`define SYNC_MAX_HALF 3

`endif

// ===== gpio_pin_control_sync.v
// Eight-pin general-purpose I/O port with pin synchroniser, sleep clamp
// and pin change interrupt flags.
// Assumes a single-cycle register port master on clk and a pad cell that
// resolves the pin level from pad_out, pad_oe_n and pullup_en.
// Assumes sleep_clamp comes from logic on clk; pad_in is asynchronous and
// only reaches registers through the per-pin synchroniser, apart from the
// clamp gate that sits ahead of it.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "gpio_port_map.vh"

module gpio_pin_control_sync #(
   parameter PINS = 8
) (
   input wire clk,
   input wire rstn,
   input wire [`ADDR_W-1:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire [PINS-1:0] pad_in,
   output reg [PINS-1:0] pad_out,
   output reg [PINS-1:0] pad_oe_n,
   output reg [PINS-1:0] pullup_en,
   input wire sleep_clamp,
   output reg irq
);

   function hit;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // Software-visible registers and their next values
   reg [PINS-1:0] port_direction_reg;
   reg [PINS-1:0] port_direction_next;
   reg [PINS-1:0] port_output_data_reg;
   reg [PINS-1:0] port_output_data_next;
   reg global_pullup_disable_reg;
   reg global_pullup_disable_next;

   // Interrupt flags and enables
   reg [PINS-1:0] irq_status_reg;
   reg [PINS-1:0] irq_status_next;
   reg [PINS-1:0] irq_enable_reg;
   reg [PINS-1:0] irq_enable_next;

   // Synchroniser stages
   reg [PINS-1:0] port_input_sample_reg;
   reg [PINS-1:0] sample_prev_reg;
   reg [PINS-1:0] sync_latch_reg;

   // Read path and pin-level signals
   reg [7:0] rdata_next;
   wire [PINS-1:0] digital_in;
   wire [PINS-1:0] clamp_on;
   wire [PINS-1:0] pin_change;

   // Digital input ahead of the synchroniser, clamped in deep sleep unless the pin's interrupt is enabled
   genvar i;
   generate
      for (i = 0; i < PINS; i = i + 1) begin : g_pin
         assign clamp_on[i] = sleep_clamp & ~irq_enable_reg[i];
         assign digital_in[i] = pad_in[i] & ~clamp_on[i];
      end
   endgenerate

   // Reset images, one bit per pin or field
   localparam [PINS-1:0] SAMPLE_RESET = `RST_INPUT_SAMPLE;
   localparam [7:0] CTRL_RESET = `RST_MCU_CONTROL;

   // Two-stage synchroniser per pin: the falling-edge stage stands in for a
   // latch open while clk is high, so its value is fixed when clk falls
   genvar j;
   generate
      for (j = 0; j < PINS; j = j + 1) begin : g_sync
         always @(negedge clk or negedge rstn) begin
            if (!rstn) begin
               sync_latch_reg[j] <= SAMPLE_RESET[j];
            end else begin
               sync_latch_reg[j] <= digital_in[j];
            end
         end

         // Second stage: the only reader of the first
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               port_input_sample_reg[j] <= SAMPLE_RESET[j];
            end else begin
               port_input_sample_reg[j] <= sync_latch_reg[j];
            end
         end

         // Previous sample, for change detection
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               sample_prev_reg[j] <= SAMPLE_RESET[j];
            end else begin
               sample_prev_reg[j] <= port_input_sample_reg[j];
            end
         end
      end
   endgenerate

   // Any level change of a sampled pin; clamp release shows as a rise, which
   // flags a high pin on wake even with its interrupt disabled
   generate
      for (i = 0; i < PINS; i = i + 1) begin : g_change
         assign pin_change[i] = port_input_sample_reg[i] ^ sample_prev_reg[i];
      end
   endgenerate

   // Direction register writes
   always @* begin
      port_direction_next = port_direction_reg;
      if (wr) begin
         if (hit(addr, `OFF_DIRECTION)) begin
            port_direction_next = wdata[PINS-1:0];
         end
      end
   end

   // Output data writes; ones written at the input sample offset toggle,
   // zeros there leave the bit alone
   always @* begin
      port_output_data_next = port_output_data_reg;
      if (wr) begin
         if (hit(addr, `OFF_OUTPUT_DATA)) begin
            port_output_data_next = wdata[PINS-1:0];
         end else if (hit(addr, `OFF_INPUT_SAMPLE)) begin
            port_output_data_next = port_output_data_reg ^ wdata[PINS-1:0];
         end
      end
   end

   // Control register writes: only the pull-up disable bit is kept
   always @* begin
      global_pullup_disable_next = global_pullup_disable_reg;
      if (wr) begin
         if (hit(addr, `OFF_MCU_CONTROL)) begin
            global_pullup_disable_next = wdata[`CTRL_PUD_BIT];
         end
      end
   end

   // Interrupt enable writes; an enabled pin also escapes the sleep clamp
   always @* begin
      irq_enable_next = irq_enable_reg;
      if (wr) begin
         if (hit(addr, `OFF_IRQ_ENABLE)) begin
            irq_enable_next = wdata[PINS-1:0];
         end
      end
   end

   // Status flags: write-one clear, but a change in the clearing cycle wins
   always @* begin
      irq_status_next = irq_status_reg;
      if (wr) begin
         if (hit(addr, `OFF_IRQ_CLEAR)) begin
            irq_status_next = irq_status_reg & ~wdata[PINS-1:0];
         end
      end
      irq_status_next = irq_status_next | pin_change;
   end

   // Read multiplexer; unmapped and write-only offsets read as zero
   function [7:0] read_word;
      input [`ADDR_W-1:0] a;
      input [PINS-1:0] dir_v;
      input [PINS-1:0] data_v;
      input [PINS-1:0] sample_v;
      input pud_v;
      input [PINS-1:0] status_v;
      input [PINS-1:0] enable_v;
      begin
         read_word = 8'h00;
         if (hit(a, `OFF_DIRECTION)) begin
            read_word[PINS-1:0] = dir_v;
         end else if (hit(a, `OFF_OUTPUT_DATA)) begin
            read_word[PINS-1:0] = data_v;
         end else if (hit(a, `OFF_INPUT_SAMPLE)) begin
            read_word[PINS-1:0] = sample_v;
         end else if (hit(a, `OFF_MCU_CONTROL)) begin
            read_word[`CTRL_PUD_BIT] = pud_v;
         end else if (hit(a, `OFF_IRQ_STATUS)) begin
            read_word[PINS-1:0] = status_v;
         end else if (hit(a, `OFF_IRQ_ENABLE)) begin
            read_word[PINS-1:0] = enable_v;
         end
      end
   endfunction

   // Read data, registered so that it stands only in the cycle after the strobe
   always @* begin
      rdata_next = 8'h00;
      if (rd) begin
         rdata_next = read_word(addr, port_direction_reg, port_output_data_reg, port_input_sample_reg,
                                global_pullup_disable_reg, irq_status_reg, irq_enable_reg);
      end
   end

   // Configuration registers
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_direction_reg <= `RST_DIRECTION;
         port_output_data_reg <= `RST_OUTPUT_DATA;
         global_pullup_disable_reg <= CTRL_RESET[`CTRL_PUD_BIT];
      end else begin
         port_direction_reg <= port_direction_next;
         port_output_data_reg <= port_output_data_next;
         global_pullup_disable_reg <= global_pullup_disable_next;
      end
   end

   // Interrupt flags and enables
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_status_reg <= `RST_IRQ_STATUS;
         irq_enable_reg <= `RST_IRQ_ENABLE;
      end else begin
         irq_status_reg <= irq_status_next;
         irq_enable_reg <= irq_enable_next;
      end
   end

   // Level interrupt, high while an enabled flag is set
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_next & irq_enable_next);
      end
   end

   // Read data register
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rdata_next;
      end
   end

   // Pin modes by direction and data: 00 tri-state, 01 input with pull-up
   // unless globally disabled, 10 driven low, 11 driven high. Software must
   // step through an intermediate mode; the port does not enforce it.
   // Pull-up decode of one pin: input, data one, global disable clear
   function pullup_on;
      input dir_bit;
      input data_bit;
      input disable_bit;
      begin
         pullup_on = ~dir_bit & data_bit & ~disable_bit;
      end
   endfunction

   // Output enable of one pin, active low while the pin is driven
   function drive_off_n;
      input dir_bit;
      begin
         drive_off_n = ~dir_bit;
      end
   endfunction

   // Pad controls per pin, following the next register values so that the
   // pins move on the write edge itself
   genvar k;
   generate
      for (k = 0; k < PINS; k = k + 1) begin : g_pad
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               pad_out[k] <= 1'b0;
               pad_oe_n[k] <= 1'b1;
               pullup_en[k] <= 1'b0;
            end else begin
               pad_out[k] <= port_output_data_next[k];
               pad_oe_n[k] <= drive_off_n(port_direction_next[k]);
               pullup_en[k] <= pullup_on(port_direction_next[k], port_output_data_next[k],
                                         global_pullup_disable_next);
            end
         end
      end
   endgenerate

endmodule

// ===== gpio_pad_model.sv
// Pad and board model: resolves each pin level.
// Assumes ext_en marks pins the board drives.
`timescale 1ns/1ps
module gpio_pad_model (
   input wire clk,
   input wire [7:0] pad_out,
   input wire [7:0] pad_oe_n,
   input wire [7:0] pullup_en,
   input wire [7:0] ext_en,
   input wire [7:0] ext_val,
   output wire [7:0] pad_in
);
   reg flip = 1'b0;
   always @(posedge clk) begin
      flip <= ~flip;
   end
   // Driver wins; undriven pins without pull-up wander
   assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
      | (pad_oe_n & ~ext_en & (pullup_en | {8{flip}}));
endmodule

// ===== gpio_port_asserts.sv
// Port assertions for the GPIO port.
// Assumes binding to gpio_pin_control_sync.
`timescale 1ns/1ps
module gpio_port_asserts (
   input wire clk,
   input wire rstn,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata,
   input wire [7:0] pad_out,
   input wire [7:0] pad_oe_n,
   input wire [7:0] pullup_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_tgl; wr && addr == 4'h2 |=> pad_out == ($past(pad_out) ^ $past(wdata)); endproperty
   a_tgl: assert property (p_tgl) else $error("toggle wrong");
   property p_wr0; wr && addr == 4'h2 && wdata == 8'h00 |=> $stable(pad_out); endproperty
   a_wr0: assert property (p_wr0) else $error("zero write changed data");
   property p_dir; wr && addr == 4'h0 |=> pad_oe_n == ~$past(wdata); endproperty
   a_dir: assert property (p_dir) else $error("direction wrong");
   property p_dat; wr && addr == 4'h1 |=> pad_out == $past(wdata); endproperty
   a_dat: assert property (p_dat) else $error("drive level wrong");
   property p_pud; wr && addr == 4'h3 && wdata[0] |=> pullup_en == 8'h00; endproperty
   a_pud: assert property (p_pud) else $error("pull-up not off");
   property p_rst; disable iff (1'b0) !rstn |-> pad_oe_n == 8'hff && pullup_en == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("reset pins wrong");
   property p_rdd; rd && addr == 4'h0 |=> rdata == ~$past(pad_oe_n); endproperty
   a_rdd: assert property (p_rdd) else $error("direction read wrong");
   property p_rd0; !rd |=> rdata == 8'h00; endproperty
   a_rd0: assert property (p_rd0) else $error("read data not idle");
endmodule
bind gpio_pin_control_sync gpio_port_asserts u_chk (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .pad_out,
   .pad_oe_n, .pullup_en);

// ===== test_gpio_pin_control_sync.sv
// Self-checking bench for the GPIO port against a reference model.
// Assumes offsets 0..6 and one-cycle read latency.
`timescale 1ns/1ps
module test_gpio_pin_control_sync;
   reg clk = 1'b0, rstn = 1'b1, wr = 1'b0, rd = 1'b0, sleep_clamp = 1'b0;
   reg [3:0] addr = 4'h0;
   reg [7:0] wdata = 8'h00, ext_val = 8'h00, ext_en = 8'hff;
   wire [7:0] rdata, pad_in, pad_out, pad_oe_n, pullup_en;
   wire irq;
   integer mismatches = 0, checks_done = 0, i, x;
   integer dir = 0, dat = 0, global_pullup_disable = 0, en = 0, st = 0, s = 0, ns;
   always #12.5 clk = ~clk;
   gpio_pin_control_sync i_dut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .pad_in, .pad_out, .pad_oe_n,
      .pullup_en, .sleep_clamp, .irq);
   gpio_pad_model i_pad (.clk, .pad_out, .pad_oe_n, .pullup_en, .ext_en, .ext_val, .pad_in);
   task chk(input [63:0] n, input [7:0] e, input [7:0] g);
      begin
         checks_done = checks_done + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("mismatch %s exp %h got %h", n, e, g);
         end
      end
   endtask
   task wr_t(input [3:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rd_t(input [63:0] n, input [3:0] a, input [7:0] e);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 chk(n, e, rdata);
      end
   endtask
   // Expected sample; any change sets sticky status
   task upd;
      begin
         ns = ((dir & dat) | (~dir & ext_val)) & (sleep_clamp ? en : 255) & 255;
         st = st | (s ^ ns);
         s = ns;
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      #100000;
      mismatches = mismatches + 1;
      finish_test;
   end
   initial begin
      x = $urandom(61);
      #1 rstn = 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rd_t("unmap", 4'h7, 8'h00);
      for (i = 0; i < 12; i = i + 1) begin
         sleep_clamp <= i[1];
         ext_val <= $urandom;
         @(posedge clk);
         upd;
         x = $urandom & 255;
         wr_t(4'h6, x); en = x; upd;
         wr_t(4'h3, i & 1); global_pullup_disable = i & 1;
         x = $urandom & 255;
         wr_t(4'h0, x); dir = x; upd;
         x = $urandom & 255;
         wr_t(4'h1, x); dat = x; upd;
         x = $urandom & 255;
         wr_t(4'h2, x); dat = dat ^ x; upd;
         rd_t("dir", 4'h0, dir);
         rd_t("data", 4'h1, dat);
         rd_t("sample", 4'h2, s);
         rd_t("enable", 4'h6, en);
         rd_t("status", 4'h4, st);
         chk("oe_n", ~dir, pad_oe_n);
         chk("out", dat, pad_out);
         chk("pullup", ~dir & dat & (global_pullup_disable ? 0 : 255), pullup_en);
         chk("irq", (st & en) != 0, {7'h00, irq});
         wr_t(4'h5, 8'hff); st = 0;
      end
      wr_t(4'h3, 8'h00);
      wr_t(4'h0, 8'h00);
      wr_t(4'h1, 8'hff);
      #1 chk("pullup", 8'hff, pullup_en);
      rstn <= 1'b0;
      #5 chk("rst_pu", 8'h00, pullup_en);
      chk("rst_oe", 8'hff, pad_oe_n);
      finish_test;
   end
endmodule
